/* rtl/ltt_pkg.sv */
/*
 Package for the link-training timer and lane-order block: state codes,
 timeout figures in their own units, derived cycle counts, carrier structs.
 Assumes a single 10 MHz clock (ref_clk).
*/
package ltt_pkg;

    localparam int unsigned CLK_PERIOD_NS      = 100;
    localparam int unsigned NUM_LANES          = 4;
    localparam int unsigned LANE_W             = 10;

    localparam int unsigned LOOPBACK_IDLE_MS   = 1;
    localparam int unsigned LOOPBACK_IDLE_NS_S = 800;
    localparam int unsigned CONFIG_IDLE_MS     = 2;
    localparam int unsigned CONFIG_IDLE_NS_S   = 1200;
    localparam int unsigned QUIET_DETECT_MS    = 12;
    localparam int unsigned QUIET_DETECT_NS_S  = 800;
    localparam int unsigned POLL_LOCK_MS       = 24;
    localparam int unsigned POLL_LOCK_NS_S     = 1600;
    localparam int unsigned POLL_RCVCFG_MS     = 48;
    localparam int unsigned POLL_RCVCFG_NS_S   = 3200;
    localparam int unsigned TS1_COUNT_NORMAL   = 1024;
    localparam int unsigned TS1_COUNT_SIM      = 48;

    // longest-time figures round down, never below one cycle
    function automatic int unsigned ns_to_cyc(input int unsigned ns);
        int unsigned c;
        c = ns / CLK_PERIOD_NS;
        return (c == 0) ? 1 : c;
    endfunction : ns_to_cyc

    localparam int unsigned LOOPBACK_IDLE_CYC   = ns_to_cyc(LOOPBACK_IDLE_MS * 1000000);
    localparam int unsigned LOOPBACK_IDLE_CYC_S = ns_to_cyc(LOOPBACK_IDLE_NS_S);
    localparam int unsigned CONFIG_IDLE_CYC     = ns_to_cyc(CONFIG_IDLE_MS * 1000000);
    localparam int unsigned CONFIG_IDLE_CYC_S   = ns_to_cyc(CONFIG_IDLE_NS_S);
    localparam int unsigned QUIET_DETECT_CYC    = ns_to_cyc(QUIET_DETECT_MS * 1000000);
    localparam int unsigned QUIET_DETECT_CYC_S  = ns_to_cyc(QUIET_DETECT_NS_S);
    localparam int unsigned POLL_LOCK_CYC       = ns_to_cyc(POLL_LOCK_MS * 1000000);
    localparam int unsigned POLL_LOCK_CYC_S     = ns_to_cyc(POLL_LOCK_NS_S);
    localparam int unsigned POLL_RCVCFG_CYC     = ns_to_cyc(POLL_RCVCFG_MS * 1000000);
    localparam int unsigned POLL_RCVCFG_CYC_S   = ns_to_cyc(POLL_RCVCFG_NS_S);

    localparam int unsigned TMR_W = 20;

    typedef enum logic [9:0] {
        ST_DETECT_QUIET   = 10'b00_0000_0001,
        ST_DETECT_ACTIVE  = 10'b00_0000_0010,
        ST_POLL_ACTIVE    = 10'b00_0000_0100,
        ST_POLL_CONFIG    = 10'b00_0000_1000,
        ST_WIDTH_START    = 10'b00_0001_0000,
        ST_CONFIG_IDLE    = 10'b00_0010_0000,
        ST_LINK_UP        = 10'b00_0100_0000,
        ST_RECOVERY_LOCK  = 10'b00_1000_0000,
        ST_RECOVERY_RCVCF = 10'b01_0000_0000,
        ST_LOOPBACK_SLAVE = 10'b10_0000_0000
    } ltt_state_t;

    // link-side events reported by the lane/symbol logic
    typedef struct packed {
        logic rx_detected;
        logic ts1_sent;
        logic poll_ok;
        logic poll_cfg_ok;
        logic width_ok;
        logic idle_ok;
        logic retrain;
        logic lock_ok;
        logic rcvcfg_ok;
        logic loopback_req;
        logic eios_rx;
        logic elec_idle;
    } ltt_events_t;

    typedef struct packed {
        logic       timeout;
        logic [3:0] which;
    } ltt_tmo_t;

endpackage : ltt_pkg

/* rtl/ltt_timeout.sv */
/*
 One restartable timeout counter: cleared on restart, counts while run,
 flags done once at its limit. Limit is fixed at elaboration.
 Assumes synchronous restart from the owning state machine.
*/
module ltt_timeout
    import ltt_pkg::*;
#(
    parameter int unsigned W     = TMR_W,
    parameter int unsigned LIMIT = 8
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic restart,
    input  wire logic run,
    output logic      done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         done;
    } ltt_tmr_st_t;

    localparam logic [W-1:0] LIM = W'(LIMIT - 1);

    ltt_tmr_st_t st_r;
    ltt_tmr_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (restart) begin
            st_nxt.cnt  = '0;
            st_nxt.done = 1'b0;
        end else if (run && !st_r.done) begin
            if (st_r.cnt == LIM) begin
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done = st_r.done;
endmodule : ltt_timeout

/* rtl/ltt_training.sv */
/*
 Link-training timers and lane-order stage of a serial-link endpoint:
 a training state machine with its timeout counters and the lane flip
 between physical channels and logical lanes.
 Assumes: fundamental reset arrives on rst_n, event inputs are synchronous
 to ref_clk, lane symbols are already in the ref_clk domain.
*/
module ltt_training
    import ltt_pkg::*;
#(
    parameter bit          sim_short_timers = 1'b0,
    parameter int unsigned NLANES           = NUM_LANES,
    parameter int unsigned LW               = LANE_W,
    parameter int unsigned LOOPBACK_CYC     = sim_short_timers ? LOOPBACK_IDLE_CYC_S
                                                                : LOOPBACK_IDLE_CYC,
    parameter int unsigned CFG_IDLE_CYC     = sim_short_timers ? CONFIG_IDLE_CYC_S
                                                                : CONFIG_IDLE_CYC,
    parameter int unsigned QUIET_CYC        = sim_short_timers ? QUIET_DETECT_CYC_S
                                                                : QUIET_DETECT_CYC,
    parameter int unsigned LOCK_CYC         = sim_short_timers ? POLL_LOCK_CYC_S
                                                                : POLL_LOCK_CYC,
    parameter int unsigned RCVCFG_CYC       = sim_short_timers ? POLL_RCVCFG_CYC_S
                                                                : POLL_RCVCFG_CYC,
    parameter int unsigned TS1_TARGET       = sim_short_timers ? TS1_COUNT_SIM
                                                                : TS1_COUNT_NORMAL
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic                   config_init_flag,
    input  wire logic                   flip_lanes,
    input  wire logic                   single_lane,
    input  wire ltt_events_t            ev,
    input  wire logic [NLANES*LW-1:0]   phy_rx_data,
    input  wire logic [NLANES*LW-1:0]   lane_tx_data,
    output logic [NLANES*LW-1:0]        lane_rx_data,
    output logic [NLANES*LW-1:0]        phy_tx_data,
    output logic [NLANES-1:0]           chan_power_down,
    output ltt_state_t                  train_state,
    output logic                        link_up,
    output ltt_tmo_t                    last_timeout
);
    typedef struct packed {
        ltt_state_t                 state;
        logic                       restart;
        logic [10:0]                ts1_cnt;
        logic                       ts1_done;
        ltt_tmo_t                   tmo;
        logic [NLANES*LW-1:0]       rx;
        logic [NLANES*LW-1:0]       tx;
        logic [NLANES-1:0]          pd;
    } ltt_core_st_t;

    localparam logic [10:0] TS1_LIM = 11'(TS1_TARGET - 1);

    ltt_core_st_t st_r;
    ltt_core_st_t st_nxt;

    logic quiet_done;
    logic lock_done;
    logic rcvcfg_done;
    logic idle_done;
    logic loop_done;

    logic in_quiet;
    logic in_lock;
    logic in_rcvcfg;
    logic in_idle;
    logic in_loop;

    logic [NLANES*LW-1:0] rx_map;
    logic [NLANES*LW-1:0] tx_map;
    logic [NLANES-1:0]    pd_map;

    assign in_quiet  = (st_r.state == ST_DETECT_QUIET);
    assign in_lock   = (st_r.state == ST_POLL_ACTIVE) || (st_r.state == ST_WIDTH_START)
                       || (st_r.state == ST_RECOVERY_LOCK);
    assign in_rcvcfg = (st_r.state == ST_POLL_CONFIG)
                       || (st_r.state == ST_RECOVERY_RCVCF);
    assign in_idle   = (st_r.state == ST_CONFIG_IDLE);
    assign in_loop   = (st_r.state == ST_LOOPBACK_SLAVE) && ev.eios_rx;

    ltt_timeout #(.LIMIT(QUIET_CYC)) u_quiet_detect_timer (
        .ref_clk (ref_clk), .rst_n (rst_n), .restart (st_r.restart),
        .run     (in_quiet), .done (quiet_done));
    ltt_timeout #(.LIMIT(LOCK_CYC)) u_polling_lock_timer (
        .ref_clk (ref_clk), .rst_n (rst_n), .restart (st_r.restart),
        .run     (in_lock), .done (lock_done));
    ltt_timeout #(.LIMIT(RCVCFG_CYC)) u_polling_rcvcfg_timer (
        .ref_clk (ref_clk), .rst_n (rst_n), .restart (st_r.restart),
        .run     (in_rcvcfg), .done (rcvcfg_done));
    ltt_timeout #(.LIMIT(CFG_IDLE_CYC)) u_config_idle_timer (
        .ref_clk (ref_clk), .rst_n (rst_n), .restart (st_r.restart),
        .run     (in_idle), .done (idle_done));
    ltt_timeout #(.LIMIT(LOOPBACK_CYC)) u_loopback_idle_timer (
        .ref_clk (ref_clk), .rst_n (rst_n), .restart (st_r.restart),
        .run     (in_loop), .done (loop_done));

    // lane order: logical lane i takes channel i, or NLANES-1-i when flipped
    for (genvar i = 0; i < NLANES; i++) begin : g_lane
        localparam int unsigned RI = NLANES - 1 - i;
        assign rx_map[i*LW +: LW] = flip_lanes ? phy_rx_data[RI*LW +: LW]
                                               : phy_rx_data[i*LW +: LW];
        assign tx_map[i*LW +: LW] = flip_lanes ? lane_tx_data[RI*LW +: LW]
                                               : lane_tx_data[i*LW +: LW];
        // single lane: only the master channel stays powered
        assign pd_map[i] = single_lane && (flip_lanes ? (i != NLANES - 1) : (i != 0));
    end

    always_comb begin
        st_nxt         = st_r;
        st_nxt.restart = 1'b0;
        st_nxt.rx      = rx_map;
        st_nxt.tx      = tx_map;
        st_nxt.pd      = pd_map;

        if (st_r.restart) begin
            st_nxt.ts1_cnt  = '0;
            st_nxt.ts1_done = 1'b0;
        end else if (st_r.state == ST_POLL_ACTIVE && ev.ts1_sent && !st_r.ts1_done) begin
            if (st_r.ts1_cnt == TS1_LIM) begin
                st_nxt.ts1_done = 1'b1;
            end else begin
                st_nxt.ts1_cnt = st_r.ts1_cnt + 11'h001;
            end
        end

        // training waits in quiet until configuration is done, no new reset needed
        unique case (st_r.state)
            ST_DETECT_QUIET: begin
                if (config_init_flag && (quiet_done || ev.rx_detected)) begin
                    st_nxt.state = ST_DETECT_ACTIVE;
                end
            end
            ST_DETECT_ACTIVE: begin
                st_nxt.state = ev.rx_detected ? ST_POLL_ACTIVE : ST_DETECT_QUIET;
            end
            ST_POLL_ACTIVE: begin
                if (ev.poll_ok && st_r.ts1_done) begin
                    st_nxt.state = ST_POLL_CONFIG;
                end else if (lock_done) begin
                    st_nxt.state = ST_DETECT_QUIET;
                end
            end
            ST_POLL_CONFIG: begin
                if (ev.poll_cfg_ok) begin
                    st_nxt.state = ST_WIDTH_START;
                end else if (rcvcfg_done) begin
                    st_nxt.state = ST_DETECT_QUIET;
                end
            end
            ST_WIDTH_START: begin
                if (ev.loopback_req) begin
                    st_nxt.state = ST_LOOPBACK_SLAVE;
                end else if (ev.width_ok) begin
                    st_nxt.state = ST_CONFIG_IDLE;
                end else if (lock_done) begin
                    st_nxt.state = ST_DETECT_QUIET;
                end
            end
            ST_CONFIG_IDLE: begin
                if (ev.idle_ok) begin
                    st_nxt.state = ST_LINK_UP;
                end else if (idle_done) begin
                    st_nxt.state = ST_DETECT_QUIET;
                end
            end
            ST_LINK_UP: begin
                if (ev.retrain) begin
                    st_nxt.state = ST_RECOVERY_LOCK;
                end
            end
            ST_RECOVERY_LOCK: begin
                if (ev.lock_ok) begin
                    st_nxt.state = ST_RECOVERY_RCVCF;
                end else if (lock_done) begin
                    st_nxt.state = ST_DETECT_QUIET;
                end
            end
            ST_RECOVERY_RCVCF: begin
                if (ev.rcvcfg_ok) begin
                    st_nxt.state = ST_CONFIG_IDLE;
                end else if (rcvcfg_done) begin
                    st_nxt.state = ST_DETECT_QUIET;
                end
            end
            ST_LOOPBACK_SLAVE: begin
                if (ev.elec_idle || loop_done) begin
                    st_nxt.state = ST_DETECT_QUIET;
                end
            end
            default: begin
                st_nxt.state = ST_DETECT_QUIET;
            end
        endcase

        // every state change restarts the timers of the state entered
        if (st_nxt.state != st_r.state) begin
            st_nxt.restart = 1'b1;
            if (st_nxt.state == ST_DETECT_QUIET && st_r.state != ST_DETECT_ACTIVE) begin
                st_nxt.tmo.timeout = 1'b1;
                unique case (1'b1)
                    lock_done:   st_nxt.tmo.which = 4'h1;
                    rcvcfg_done: st_nxt.tmo.which = 4'h2;
                    idle_done:   st_nxt.tmo.which = 4'h3;
                    loop_done:   st_nxt.tmo.which = 4'h4;
                    default:     st_nxt.tmo.which = 4'h0;
                endcase
            end
        end
        if (st_r.state == ST_LINK_UP) begin
            st_nxt.tmo.timeout = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r         <= '0;
            st_r.state   <= ST_DETECT_QUIET;
            st_r.restart <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lane_rx_data    = st_r.rx;
    assign phy_tx_data     = st_r.tx;
    assign chan_power_down = st_r.pd;
    assign train_state     = st_r.state;
    assign link_up         = (st_r.state == ST_LINK_UP);
    assign last_timeout    = st_r.tmo;
endmodule : ltt_training

/* verification/ltt_training_properties.sv */
/* Port checker for ltt_training: dwell limits, timeout exits, lane order
   and power-down. Bound into every ltt_training instance below. */
module ltt_training_properties
    import ltt_pkg::*;
#(
    parameter int unsigned LOCK_CYC     = 16,
    parameter int unsigned RCVCFG_CYC   = 32,
    parameter int unsigned CFG_IDLE_CYC = 12
) (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        config_init_flag,
    input wire logic        flip_lanes,
    input wire logic        single_lane,
    input wire logic [39:0] phy_rx_data,
    input wire logic [39:0] lane_tx_data,
    input wire logic [39:0] lane_rx_data,
    input wire logic [39:0] phy_tx_data,
    input wire logic [3:0]  chan_power_down,
    input wire ltt_state_t  train_state,
    input wire logic        link_up,
    input wire ltt_tmo_t    last_timeout
);
    timeunit 1ns;
    timeprecision 1ns;
    ltt_state_t  prev_r;
    logic [19:0] dwell_r;
    logic [19:0] age;

    // cycles since entry; +4 slack below covers registered restart and done
    assign age = (train_state != prev_r) ? 20'h0 : dwell_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r  <= ST_DETECT_QUIET;
            dwell_r <= 20'h0;
        end else begin
            prev_r  <= train_state;
            dwell_r <= age + 20'h1;
        end
    end

    function automatic logic [39:0] rev(input logic [39:0] d);
        for (int k = 0; k < 4; k++) rev[k*10+:10] = d[(3-k)*10+:10];
    endfunction : rev

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    property p_lock_max;
        train_state inside {ST_POLL_ACTIVE, ST_WIDTH_START, ST_RECOVERY_LOCK}
            |-> age <= LOCK_CYC + 4;
    endproperty
    a_lock_max: assert property (p_lock_max) else $error("lock timer overrun");
    property p_rcvcfg_max;
        train_state inside {ST_POLL_CONFIG, ST_RECOVERY_RCVCF} |-> age <= RCVCFG_CYC + 4;
    endproperty
    a_rcvcfg_max: assert property (p_rcvcfg_max) else $error("cfg timer overrun");
    property p_idle_max;
        train_state == ST_CONFIG_IDLE |-> age <= CFG_IDLE_CYC + 4;
    endproperty
    a_idle_max: assert property (p_idle_max) else $error("idle timer overrun");
    property p_lock_exit;
        train_state == ST_POLL_ACTIVE ##1 train_state == ST_DETECT_QUIET
            |-> $past(age) >= LOCK_CYC ##[0:1] last_timeout == {1'b1, 4'h1};
    endproperty
    a_lock_exit: assert property (p_lock_exit) else $error("bad lock timeout");
    property p_rcvcfg_exit;
        train_state == ST_POLL_CONFIG ##1 train_state == ST_DETECT_QUIET
            |-> $past(age) >= RCVCFG_CYC ##[0:1] last_timeout == {1'b1, 4'h2};
    endproperty
    a_rcvcfg_exit: assert property (p_rcvcfg_exit) else $error("bad cfg timeout");
    property p_hold;
        train_state == ST_DETECT_QUIET && !config_init_flag |=> train_state == ST_DETECT_QUIET;
    endproperty
    a_hold: assert property (p_hold) else $error("left quiet unconfigured");
    property p_entry;
        $changed(train_state) && train_state == ST_POLL_ACTIVE
            |-> $past(train_state) == ST_DETECT_ACTIVE;
    endproperty
    a_entry: assert property (p_entry) else $error("polling not via detect");
    property p_flip;
        flip_lanes |=> lane_rx_data == rev($past(phy_rx_data))
            && phy_tx_data == rev($past(lane_tx_data));
    endproperty
    a_flip: assert property (p_flip) else $error("reversed map wrong");
    property p_straight;
        !flip_lanes |=> lane_rx_data == $past(phy_rx_data) && phy_tx_data == $past(lane_tx_data);
    endproperty
    a_straight: assert property (p_straight) else $error("straight map wrong");
    property p_master;
        single_lane |=> chan_power_down == ($past(flip_lanes) ? 4'h7 : 4'he);
    endproperty
    a_master: assert property (p_master) else $error("power-down wrong");
    property p_up;
        link_up == (train_state == ST_LINK_UP);
    endproperty
    a_up: assert property (p_up) else $error("link_up mismatch");
endmodule : ltt_training_properties

bind ltt_training ltt_training_properties #(.LOCK_CYC(LOCK_CYC), .RCVCFG_CYC(RCVCFG_CYC),
    .CFG_IDLE_CYC(CFG_IDLE_CYC)) ltt_training_properties_i (.ref_clk, .rst_n,
    .config_init_flag, .flip_lanes, .single_lane, .phy_rx_data, .lane_tx_data,
    .lane_rx_data, .phy_tx_data, .chan_power_down, .train_state, .link_up, .last_timeout);

/* verification/ltt_link_partner.sv */
/* Link partner model: raises the far end's event for each detect, polling, configuration
   and recovery state while answer is high; replies come lag cycles after entry, one at the least. Watches train_state. */
module ltt_link_partner
    import ltt_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire ltt_state_t train_state,
    input  wire logic       answer,
    input  wire logic [3:0] lag,
    output ltt_events_t     ev
);
    timeunit 1ns;
    timeprecision 1ns;
    ltt_state_t seen_r;
    logic [3:0] wait_r;
    logic       fresh;
    logic       go;

    assign fresh = train_state != seen_r;
    assign go    = answer && !fresh && wait_r >= lag;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_r <= ST_DETECT_QUIET;
            wait_r <= 4'h0;
        end else begin
            seen_r <= train_state;
            wait_r <= fresh ? 4'h1 : wait_r + {3'h0, wait_r != 4'hf};
        end
    end

    // termination and training sets are there at once; only replies wait for lag,
    // else detect active (one cycle long) never sees the partner
    always_comb begin
        ev = '0;
        case (train_state)
            ST_DETECT_QUIET, ST_DETECT_ACTIVE: ev.rx_detected = answer;
            ST_POLL_ACTIVE: begin
                ev.ts1_sent = answer;
                ev.poll_ok  = go;
            end
            ST_POLL_CONFIG:    ev.poll_cfg_ok = go;
            ST_WIDTH_START:    ev.width_ok    = go;
            ST_CONFIG_IDLE:    ev.idle_ok     = go;
            ST_RECOVERY_LOCK:  ev.lock_ok     = go;
            ST_RECOVERY_RCVCF: ev.rcvcfg_ok   = go;
            default:           ev             = '0;
        endcase
    end
endmodule : ltt_link_partner

/* verification/test_ltt_training.sv */
/* Self-checking bench for ltt_training with short timers, the link partner
   model and the bound checker. Assumes only ltt_pkg. */
module test_ltt_training import ltt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TS1_N = 12;
    localparam int LK    = POLL_LOCK_NS_S / CLK_PERIOD_NS;
    localparam int RC    = POLL_RCVCFG_NS_S / CLK_PERIOD_NS;

    logic        ref_clk          = 1'b0;
    logic        rst_n            = 1'b0;
    logic        config_init_flag = 1'b0;
    logic        flip_lanes       = 1'b0;
    logic        single_lane      = 1'b0;
    logic        answer           = 1'b0;
    logic [3:0]  lag              = 4'h0;
    logic [39:0] phy_rx_data      = 40'h0;
    logic [39:0] lane_tx_data     = 40'h0;
    logic [39:0] lane_rx_data;
    logic [39:0] phy_tx_data;
    logic [3:0]  chan_power_down;
    logic        link_up;
    ltt_events_t tb_ev            = '0;
    ltt_events_t p_ev;
    ltt_events_t ev;
    ltt_state_t  train_state;
    ltt_tmo_t    last_timeout;
    int          miscompares      = 0;
    int          n_checks         = 0;
    int          cyc              = 0;
    int          c;

    assign ev = ltt_events_t'(tb_ev | p_ev);
    always #50 ref_clk = ~ref_clk;

    ltt_training #(.sim_short_timers(1'b1), .TS1_TARGET(TS1_N)) ltt_training_i (.ref_clk,
        .rst_n, .config_init_flag, .flip_lanes, .single_lane, .ev, .phy_rx_data,
        .lane_tx_data, .lane_rx_data, .phy_tx_data, .chan_power_down, .train_state,
        .link_up, .last_timeout);
    ltt_link_partner ltt_link_partner_i (.ref_clk, .rst_n, .train_state, .answer, .lag,
        .ev(p_ev));

    function automatic logic [39:0] rev(input logic [39:0] d);
        for (int k = 0; k < 4; k++) rev[k*10+:10] = d[(3-k)*10+:10];
    endfunction : rev

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_st(input ltt_state_t s, input int lim);
        c = 0;
        while (train_state !== s && c < lim) begin
            @(posedge ref_clk);
            #1;
            c++;
        end
        chk({30'h0, train_state}, {30'h0, s});
    endtask : wait_st

    // reset hold is 8 cycles, far short of a real power-up hold
    task automatic do_reset(input logic cfg, input logic ans, input logic [3:0] lg);
        @(posedge ref_clk);
        rst_n            <= 1'b0;
        config_init_flag <= cfg;
        answer           <= ans;
        lag              <= lg;
        tb_ev            <= '0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
    endtask : do_reset

    task automatic tmo_chk(input int lim, input logic [3:0] which);
        wait_st(ST_DETECT_QUIET, lim + 8);
        chk({39'h0, c + 1 >= lim && c + 1 <= lim + 4}, 40'h1);
        @(posedge ref_clk);
        #1;
        chk({35'h0, last_timeout}, {35'h0, 1'b1, which});
    endtask : tmo_chk

    task automatic enter_poll;
        do_reset(1'b1, 1'b0, 4'h0);
        @(posedge ref_clk);
        tb_ev.rx_detected <= 1'b1;
        wait_st(ST_POLL_ACTIVE, 30);
        @(posedge ref_clk);
    endtask : enter_poll

    task automatic t_late_config;
        do_reset(1'b0, 1'b1, 4'h0);
        chk({39'h0, link_up}, 40'h0);
        chk({36'h0, chan_power_down}, 40'h0);
        repeat (40) @(posedge ref_clk);
        #1;
        wait_st(ST_DETECT_QUIET, 0);
        @(posedge ref_clk);
        config_init_flag <= 1'b1;
        wait_st(ST_LINK_UP, 200);
        chk({39'h0, link_up}, 40'h1);
        $display("late configuration test done");
    endtask : t_late_config

    task automatic t_early_config;
        do_reset(1'b1, 1'b1, 4'h3);
        wait_st(ST_POLL_ACTIVE, 40);
        wait_st(ST_LINK_UP, 200);
        @(posedge ref_clk);
        tb_ev.retrain <= 1'b1;
        @(posedge ref_clk);
        tb_ev.retrain <= 1'b0;
        #1;
        wait_st(ST_RECOVERY_LOCK, 0);
        wait_st(ST_RECOVERY_RCVCF, 20);
        wait_st(ST_LINK_UP, 100);
        $display("early configuration and retrain test done");
    endtask : t_early_config

    task automatic t_lock_tmo;
        enter_poll;
        tb_ev <= '0;
        tmo_chk(LK, 4'h1);
        $display("polling timeout test done");
    endtask : t_lock_tmo

    // one short of the count must hold polling; the last set releases it
    task automatic t_ts1;
        enter_poll;
        tb_ev <= '{ts1_sent: 1'b1, poll_ok: 1'b1, default: 1'b0};
        repeat (TS1_N - 1) @(posedge ref_clk);
        tb_ev.ts1_sent <= 1'b0;
        @(posedge ref_clk);
        #1;
        wait_st(ST_POLL_ACTIVE, 0);
        @(posedge ref_clk);
        tb_ev.ts1_sent <= 1'b1;
        @(posedge ref_clk);
        tb_ev.ts1_sent <= 1'b0;
        wait_st(ST_POLL_CONFIG, 3);
        @(posedge ref_clk);
        tb_ev.poll_ok <= 1'b0;
        tmo_chk(RC - 1, 4'h2);
        $display("training set count test done");
    endtask : t_ts1

    task automatic t_loopback;
        do_reset(1'b1, 1'b1, 4'h2);
        @(posedge ref_clk);
        tb_ev <= '{loopback_req: 1'b1, eios_rx: 1'b1, default: 1'b0};
        wait_st(ST_LOOPBACK_SLAVE, 100);
        tmo_chk(LOOPBACK_IDLE_NS_S / CLK_PERIOD_NS, 4'h4);
        $display("loopback timeout test done");
    endtask : t_loopback

    task automatic t_lanes;
        logic [39:0] px;
        for (int m = 0; m < 4; m++) begin
            px = 40'hf1_e2d3_c4b5 + 40'(m);
            @(posedge ref_clk);
            flip_lanes   <= m[0];
            single_lane  <= m[1];
            phy_rx_data  <= px;
            lane_tx_data <= ~px;
            @(posedge ref_clk);
            #1;
            chk(lane_rx_data, m[0] ? rev(px) : px);
            chk(phy_tx_data, m[0] ? rev(~px) : ~px);
            chk({36'h0, chan_power_down}, {36'h0, m[1] ? (m[0] ? 4'h7 : 4'he) : 4'h0});
        end
        $display("lane order test done");
    endtask : t_lanes

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    // whole run is well under a thousand cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            results;
        end
    end

    initial begin
        t_late_config;
        t_early_config;
        t_lock_tmo;
        t_ts1;
        t_loopback;
        t_lanes;
        results;
    end
endmodule : test_ltt_training
